// ===== hw/ccs_params.svh
// Register map, field positions, reset values and timing counts for the clock setup block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// Register offsets on the control port
`define CCS_ADDR_CLOCK_CONTROL 8'h00
`define CCS_ADDR_PLL_DEN_HIGH 8'h01
`define CCS_ADDR_PLL_DEN_LOW 8'h02
`define CCS_ADDR_PLL_NUM_HIGH 8'h03
`define CCS_ADDR_PLL_NUM_LOW 8'h04
`define CCS_ADDR_PLL_INT_DIV_MODE 8'h05
`define CCS_ADDR_PLL_LOCK_STATUS 8'h06
`define CCS_ADDR_AUX_CLOCK_CONTROL 8'h07
`define CCS_ADDR_MP_PIN_MODE 8'h38

// Clock control register fields
`define CCS_CLK_PLL_ENABLE_BIT 7
`define CCS_CLK_SOURCE_PLL_BIT 3
`define CCS_CLK_HALVER_BIT 1
`define CCS_CLK_GATE_BIT 0

// Integer, divider and mode register fields
`define CCS_PLL_INT_MSB 6
`define CCS_PLL_INT_LSB 3
`define CCS_PLL_DIV_MSB 2
`define CCS_PLL_DIV_LSB 1
`define CCS_PLL_FRAC_BIT 0

// Auxiliary clock control fields; factor code 0..4 = x2, x1, /2, /4, /8
`define CCS_AUX_ENABLE_BIT 0
`define CCS_AUX_PDM_BIT 1
`define CCS_AUX_FACTOR_MSB 4
`define CCS_AUX_FACTOR_LSB 2
`define CCS_AUX_FACTOR_X1 3'h1
`define CCS_AUX_FACTOR_DIV8 3'h4

// Multipurpose pin mode fields
`define CCS_MP_FUNC_MSB 3
`define CCS_MP_FUNC_LSB 0
`define CCS_MP_INVERT_BIT 4
`define CCS_MP_FUNC_MUTE_DACS 4'h6

// Reset values
`define CCS_RESET_BYTE 8'h00

// Timing
`define CCS_CLOCK_PERIOD_NS 10
`define CCS_PLL_LOCK_TIME_NS 1000
`define CCS_PLL_LOCK_CYCLES ((`CCS_PLL_LOCK_TIME_NS + `CCS_CLOCK_PERIOD_NS - 1) / `CCS_CLOCK_PERIOD_NS)

`endif

// ===== hw/ccs_pkg.sv
// Types shared by the clock setup block and its surroundings
package ccs_pkg;

   // One access on the control port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccs_reg_req_t;

   // Settings handed to the analog PLL core
   typedef struct packed {
      logic [1:0] input_div;
      logic [3:0] integer_mult;
      logic [15:0] numerator;
      logic [15:0] denominator;
      logic fractional;
   } ccs_pll_cfg_t;

   // Lock acquisition states, Gray coded along off, acquire, locked
   typedef enum logic [1:0] {
      CCS_PLL_OFF = 2'b00,
      CCS_PLL_ACQUIRE = 2'b01,
      CCS_PLL_LOCKED = 2'b11
   } ccs_lock_state_t;

endpackage

// ===== hw/ccs_clock_setup.sv
// Clock setup: PLL control registers, lock tracking, master clock gate and aux clock output
// Functional notes
// (R1) Master clock gate resets closed and stays closed while the PLL acquires lock; here only while 0x00 bit 3 selects the PLL as source.
// (R2) Register 0x06 bit 0 is a read-only PLL lock flag.
// (R3) Setting the gate bit distributes master clock to all internal blocks.
// (R4) Software clears loop enable, writes 0x01-0x05, enables, polls lock, opens gate.
// (R5) Until gate and lock are both set, only registers 0x00-0x06 are reachable; here the gate bit alone opens the rest when 0x00 bit 3 is clear.
// (R6) PLL reference is the reference clock pin, 8 to 27 MHz.
// (R7) Input divider field is 0x05 bits 2:1; ratio is field plus one.
// (R8) Integer mode ignores numerator and denominator.
// (R9) Output equals divided reference times half of integer plus fraction.
// (R10) Software keeps fractional ratio between 0.1 and 0.9.
// (R11) Software keeps PLL output between 20.5 and 27 MHz, nominally 24.576.
// (R12) Integer settings: 0x20 for 12.288 MHz, 0x10 for 24.576 MHz reference.
// (R13) Denominator in 0x01/0x02, numerator in 0x03/0x04, high byte first.
// (R14) Register 0x05 holds integer multiplier in bits 6:3, fractional select bit 0.
// (R15) Aux clock output is master clock times 2, 1, 1/2, 1/4 or 1/8.
// (R16) In PDM mode only the sub-unity factors drive the aux clock.
// (R17) Software uses the times-two factor only with the master clock halver active.
// (R18) Aux clock shares its pin with the second capture serial output.
// (R19) Low power-down pin powers down all circuits; high means normal operation.
// (R20) Host mutes outputs before pulling the power-down pin low.
// (R21) Multipurpose pin configured through 0x38-0x3E can mute both DACs.
// (R22) Master clock halver is 0x00 bit 1: 1 divides by one, 0 by two.
// (R23) Lock flag reads zero while disabled or acquiring, one once stable.
`timescale 1ns/10ps
`include "ccs_params.svh"

module ccs_clock_setup #(
   parameter int unsigned LOCK_CYCLES = `CCS_PLL_LOCK_CYCLES,
   parameter int unsigned AUX_COUNT_WIDTH = 5
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic power_down_pin_active_low,
   input wire ccs_pkg::ccs_reg_req_t reg_req,
   input wire logic aux_tick,
   input wire logic capture_serial_out_second_data,
   input wire logic multipurpose_pin,
   output logic [7:0] reg_rdata,
   output logic reg_rd_valid,
   output logic reg_refused,
   output ccs_pkg::ccs_pll_cfg_t pll_cfg,
   output logic pll_enable,
   output logic pll_locked,
   output logic core_clock_gate,
   output logic core_clock_halver,
   output logic circuits_powered,
   output logic auxiliary_clock_output,
   output logic dac_mute
);
   import ccs_pkg::*;

   // Elaboration-time guard on parameters the logic cannot serve
   if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_bad_lock
      $error("LOCK_CYCLES must lie in 1..65535");
   end
   // The divide-by-eight factor counts 16 ticks, which needs a five-bit counter
   if (AUX_COUNT_WIDTH < 5) begin : g_bad_aux
      $error("AUX_COUNT_WIDTH must be at least 5 to reach the divide-by-eight factor");
   end

   localparam logic [15:0] LOCK_LAST = 16'(LOCK_CYCLES - 1);

   // True for the PLL parameter registers 0x01 to 0x05
   function automatic logic is_pll_param(input logic [7:0] addr);
      return (addr >= `CCS_ADDR_PLL_DEN_HIGH) && (addr <= `CCS_ADDR_PLL_INT_DIV_MODE);
   endfunction

   // Ticks between aux clock edges for a factor code; zero means no clock
   function automatic logic [AUX_COUNT_WIDTH-1:0] aux_half_ticks(input logic [2:0] code);
      if (code > `CCS_AUX_FACTOR_DIV8) begin
         return '0;
      end
      return AUX_COUNT_WIDTH'(1) << code;
   endfunction

   // Register group
   logic [7:0] clock_control_reg, clock_control_next;
   logic [7:0] pll_denominator_high_reg, pll_denominator_high_next;
   logic [7:0] pll_denominator_low_reg, pll_denominator_low_next;
   logic [7:0] pll_numerator_high_reg, pll_numerator_high_next;
   logic [7:0] pll_numerator_low_reg, pll_numerator_low_next;
   logic [7:0] pll_integer_divider_mode_reg, pll_integer_divider_mode_next;
   logic [7:0] aux_clock_control_reg, aux_clock_control_next;
   logic [7:0] mp_pin_mode_reg, mp_pin_mode_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rd_valid_reg, rd_valid_next;
   logic refused_reg, refused_next;

   // Lock group
   ccs_lock_state_t lock_state_reg, lock_state_next;
   logic [15:0] lock_count_reg, lock_count_next;
   logic lock_flag_reg, lock_flag_next;

   // Aux clock group
   logic [AUX_COUNT_WIDTH-1:0] aux_count_reg, aux_count_next;
   logic aux_clk_reg, aux_clk_next;

   // Output group
   ccs_pll_cfg_t pll_cfg_reg, pll_cfg_next;
   logic pll_enable_reg, pll_enable_next;
   logic gate_reg, gate_next;
   logic halver_reg, halver_next;
   logic powered_reg, powered_next;
   logic aux_pin_reg, aux_pin_next;
   logic mute_reg, mute_next;

   logic powered_up;
   logic gate_open;
   logic fence_open;
   logic param_write;
   logic access;
   logic [2:0] aux_factor;
   logic aux_allowed;
   logic [AUX_COUNT_WIDTH-1:0] aux_half;

   // Shared status terms
   assign powered_up = power_down_pin_active_low; // R19
   // Gate only opens with the PLL locked when the PLL is the source
   assign gate_open = clock_control_reg[`CCS_CLK_GATE_BIT] &
                      (lock_flag_reg | ~clock_control_reg[`CCS_CLK_SOURCE_PLL_BIT]); // R1 R3
   assign fence_open = gate_open; // R5
   assign access = reg_req.wr | reg_req.rd;
   assign param_write = reg_req.wr & is_pll_param(reg_req.addr);

   // Register file next state; a refused access stores nothing and reads nothing
   always_comb begin
      clock_control_next = clock_control_reg;
      pll_denominator_high_next = pll_denominator_high_reg;
      pll_denominator_low_next = pll_denominator_low_reg;
      pll_numerator_high_next = pll_numerator_high_reg;
      pll_numerator_low_next = pll_numerator_low_reg;
      pll_integer_divider_mode_next = pll_integer_divider_mode_reg;
      aux_clock_control_next = aux_clock_control_reg;
      mp_pin_mode_next = mp_pin_mode_reg;
      rdata_next = rdata_reg;
      rd_valid_next = 1'b0;
      refused_next = 1'b0;
      if (!powered_up) begin
         // Power-down returns every register to reset
         clock_control_next = `CCS_RESET_BYTE; // R19
         pll_denominator_high_next = `CCS_RESET_BYTE;
         pll_denominator_low_next = `CCS_RESET_BYTE;
         pll_numerator_high_next = `CCS_RESET_BYTE;
         pll_numerator_low_next = `CCS_RESET_BYTE;
         pll_integer_divider_mode_next = `CCS_RESET_BYTE;
         aux_clock_control_next = `CCS_RESET_BYTE;
         mp_pin_mode_next = `CCS_RESET_BYTE;
         rdata_next = `CCS_RESET_BYTE;
      end else if (access && reg_req.addr > `CCS_ADDR_PLL_LOCK_STATUS && !fence_open) begin
         refused_next = 1'b1; // R5
      end else if (access) begin
         if (reg_req.wr) begin
            unique case (reg_req.addr)
               `CCS_ADDR_CLOCK_CONTROL: clock_control_next = reg_req.wdata; // R22
               `CCS_ADDR_PLL_DEN_HIGH: pll_denominator_high_next = reg_req.wdata; // R13
               `CCS_ADDR_PLL_DEN_LOW: pll_denominator_low_next = reg_req.wdata; // R13
               `CCS_ADDR_PLL_NUM_HIGH: pll_numerator_high_next = reg_req.wdata; // R13
               `CCS_ADDR_PLL_NUM_LOW: pll_numerator_low_next = reg_req.wdata; // R13
               `CCS_ADDR_PLL_INT_DIV_MODE: pll_integer_divider_mode_next = reg_req.wdata; // R14
               `CCS_ADDR_AUX_CLOCK_CONTROL: aux_clock_control_next = reg_req.wdata;
               `CCS_ADDR_MP_PIN_MODE: mp_pin_mode_next = reg_req.wdata; // R21
               default: ; // Lock status is read-only; other addresses ignore writes
            endcase
         end
         if (reg_req.rd) begin
            rd_valid_next = 1'b1;
            unique case (reg_req.addr)
               `CCS_ADDR_CLOCK_CONTROL: rdata_next = clock_control_reg;
               `CCS_ADDR_PLL_DEN_HIGH: rdata_next = pll_denominator_high_reg;
               `CCS_ADDR_PLL_DEN_LOW: rdata_next = pll_denominator_low_reg;
               `CCS_ADDR_PLL_NUM_HIGH: rdata_next = pll_numerator_high_reg;
               `CCS_ADDR_PLL_NUM_LOW: rdata_next = pll_numerator_low_reg;
               `CCS_ADDR_PLL_INT_DIV_MODE: rdata_next = pll_integer_divider_mode_reg;
               `CCS_ADDR_PLL_LOCK_STATUS: rdata_next = {7'h00, lock_flag_reg}; // R2
               `CCS_ADDR_AUX_CLOCK_CONTROL: rdata_next = aux_clock_control_reg;
               `CCS_ADDR_MP_PIN_MODE: rdata_next = mp_pin_mode_reg;
               default: rdata_next = 8'h00;
            endcase
         end
      end
   end

   // Register file storage
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         clock_control_reg <= `CCS_RESET_BYTE; // R1
         pll_denominator_high_reg <= `CCS_RESET_BYTE;
         pll_denominator_low_reg <= `CCS_RESET_BYTE;
         pll_numerator_high_reg <= `CCS_RESET_BYTE;
         pll_numerator_low_reg <= `CCS_RESET_BYTE;
         pll_integer_divider_mode_reg <= `CCS_RESET_BYTE;
         aux_clock_control_reg <= `CCS_RESET_BYTE;
         mp_pin_mode_reg <= `CCS_RESET_BYTE;
         rdata_reg <= `CCS_RESET_BYTE;
         rd_valid_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else if (clk_en) begin
         clock_control_reg <= clock_control_next;
         pll_denominator_high_reg <= pll_denominator_high_next;
         pll_denominator_low_reg <= pll_denominator_low_next;
         pll_numerator_high_reg <= pll_numerator_high_next;
         pll_numerator_low_reg <= pll_numerator_low_next;
         pll_integer_divider_mode_reg <= pll_integer_divider_mode_next;
         aux_clock_control_reg <= aux_clock_control_next;
         mp_pin_mode_reg <= mp_pin_mode_next;
         rdata_reg <= rdata_next;
         rd_valid_reg <= rd_valid_next;
         refused_reg <= refused_next;
      end
   end

   // Lock tracking; a parameter write while running restarts acquisition,
   // since the loop retunes and the old lock no longer holds
   always_comb begin
      lock_state_next = lock_state_reg;
      lock_count_next = lock_count_reg;
      if (!powered_up || !clock_control_reg[`CCS_CLK_PLL_ENABLE_BIT]) begin
         lock_state_next = CCS_PLL_OFF; // R23
         lock_count_next = 16'h0000;
      end else begin
         unique case (lock_state_reg)
            CCS_PLL_OFF: begin
               lock_state_next = CCS_PLL_ACQUIRE;
               lock_count_next = 16'h0000;
            end
            CCS_PLL_ACQUIRE: begin
               if (param_write) begin
                  lock_count_next = 16'h0000;
               end else if (lock_count_reg == LOCK_LAST) begin
                  lock_state_next = CCS_PLL_LOCKED; // R23
               end else begin
                  lock_count_next = lock_count_reg + 16'h0001;
               end
            end
            CCS_PLL_LOCKED: begin
               if (param_write) begin
                  lock_state_next = CCS_PLL_ACQUIRE;
                  lock_count_next = 16'h0000;
               end
            end
            default: begin
               lock_state_next = CCS_PLL_OFF;
               lock_count_next = 16'h0000;
            end
         endcase
      end
      lock_flag_next = (lock_state_next == CCS_PLL_LOCKED); // R2 R23
   end

   // Lock storage
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lock_state_reg <= CCS_PLL_OFF;
         lock_count_reg <= 16'h0000;
         lock_flag_reg <= 1'b0;
      end else if (clk_en) begin
         lock_state_reg <= lock_state_next;
         lock_count_reg <= lock_count_next;
         lock_flag_reg <= lock_flag_next;
      end
   end

   // Aux clock divider: aux_tick marks a half period of the x2 output,
   // so every factor toggles after a power-of-two number of ticks
   assign aux_factor = aux_clock_control_reg[`CCS_AUX_FACTOR_MSB:`CCS_AUX_FACTOR_LSB];
   assign aux_half = aux_half_ticks(aux_factor); // R15
   // PDM mode suppresses the x2 and x1 factors
   assign aux_allowed = gate_open && aux_half != '0 &&
                        !(aux_clock_control_reg[`CCS_AUX_PDM_BIT] &&
                          aux_factor <= `CCS_AUX_FACTOR_X1); // R16
   always_comb begin
      aux_count_next = aux_count_reg;
      aux_clk_next = aux_clk_reg;
      if (!aux_allowed) begin
         aux_count_next = '0;
         aux_clk_next = 1'b0;
      end else if (aux_tick) begin
         if (aux_count_reg + AUX_COUNT_WIDTH'(1) >= aux_half) begin
            aux_count_next = '0;
            aux_clk_next = ~aux_clk_reg; // R15
         end else begin
            aux_count_next = aux_count_reg + AUX_COUNT_WIDTH'(1);
         end
      end
   end

   // Aux clock storage
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aux_count_reg <= '0;
         aux_clk_reg <= 1'b0;
      end else if (clk_en) begin
         aux_count_reg <= aux_count_next;
         aux_clk_reg <= aux_clk_next;
      end
   end

   // Output values, each registered so the pins never glitch
   always_comb begin
      pll_cfg_next.input_div =
         pll_integer_divider_mode_reg[`CCS_PLL_DIV_MSB:`CCS_PLL_DIV_LSB]; // R7
      pll_cfg_next.integer_mult =
         pll_integer_divider_mode_reg[`CCS_PLL_INT_MSB:`CCS_PLL_INT_LSB]; // R14 R9
      pll_cfg_next.fractional = pll_integer_divider_mode_reg[`CCS_PLL_FRAC_BIT]; // R14
      // Fraction forced to zero in integer mode so the core sees a clean ratio
      if (pll_integer_divider_mode_reg[`CCS_PLL_FRAC_BIT]) begin
         pll_cfg_next.numerator = {pll_numerator_high_reg, pll_numerator_low_reg}; // R13
         pll_cfg_next.denominator = {pll_denominator_high_reg, pll_denominator_low_reg}; // R13
      end else begin
         pll_cfg_next.numerator = 16'h0000; // R8
         pll_cfg_next.denominator = 16'h0000; // R8
      end
      pll_enable_next = powered_up & clock_control_reg[`CCS_CLK_PLL_ENABLE_BIT]; // R6
      gate_next = powered_up & gate_open; // R1 R3
      halver_next = clock_control_reg[`CCS_CLK_HALVER_BIT]; // R22
      powered_next = powered_up; // R19
      // Shared pin: aux clock when enabled, else the second capture serial output
      aux_pin_next = aux_clock_control_reg[`CCS_AUX_ENABLE_BIT] ? aux_clk_reg
                     : capture_serial_out_second_data; // R18
      mute_next = (mp_pin_mode_reg[`CCS_MP_FUNC_MSB:`CCS_MP_FUNC_LSB] == `CCS_MP_FUNC_MUTE_DACS)
                  & (multipurpose_pin ^ mp_pin_mode_reg[`CCS_MP_INVERT_BIT]); // R21
   end

   // Output storage
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pll_cfg_reg <= '0;
         pll_enable_reg <= 1'b0;
         gate_reg <= 1'b0; // R1
         halver_reg <= 1'b0;
         powered_reg <= 1'b0;
         aux_pin_reg <= 1'b0;
         mute_reg <= 1'b0;
      end else if (clk_en) begin
         pll_cfg_reg <= pll_cfg_next;
         pll_enable_reg <= pll_enable_next;
         gate_reg <= gate_next;
         halver_reg <= halver_next;
         powered_reg <= powered_next;
         aux_pin_reg <= aux_pin_next;
         mute_reg <= mute_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rd_valid = rd_valid_reg;
   assign reg_refused = refused_reg;
   assign pll_cfg = pll_cfg_reg;
   assign pll_enable = pll_enable_reg;
   assign pll_locked = lock_flag_reg;
   assign core_clock_gate = gate_reg;
   assign core_clock_halver = halver_reg;
   assign circuits_powered = powered_reg;
   assign auxiliary_clock_output = aux_pin_reg;
   assign dac_mute = mute_reg;

endmodule // ccs_clock_setup

// ===== test/ccs_clock_setup_asserts.sv
// Port checker for the clock setup block, bound into its top module
`timescale 1ns/10ps
module ccs_clock_setup_asserts #(
   parameter int unsigned LOCK_CYCLES = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic power_down_pin_active_low,
   input wire ccs_pkg::ccs_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rd_valid,
   input wire logic reg_refused,
   input wire logic pll_enable,
   input wire logic pll_locked,
   input wire logic core_clock_gate
);
   import ccs_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic taken;
   logic [15:0] on_reg;
   logic [15:0] on_next;
   // An access that the port takes on this edge
   assign taken = clk_en && power_down_pin_active_low && (reg_req.wr || reg_req.rd);
   // Cycles with the loop enabled; saturates so a long run never wraps
   always_comb begin
      on_next = on_reg;
      if (!pll_enable) begin
         on_next = 16'h0000;
      end else if (clk_en && on_reg != 16'hffff) begin
         on_next = on_reg + 16'h0001;
      end
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         on_reg <= 16'h0000;
      end else begin
         on_reg <= on_next;
      end
   end
   sequence s_low_read;
      taken && reg_req.rd && reg_req.addr <= 8'h06;
   endsequence
   sequence s_held_down;
      (clk_en && !power_down_pin_active_low) [*2];
   endsequence
   a_low_reachable: assert property (s_low_read |=> reg_rd_valid && !reg_refused)
      else $error("low register read not answered");
   a_valid_cause: assert property (reg_rd_valid |-> $past(taken && reg_req.rd))
      else $error("read data without a read");
   a_refuse_cause: assert property (reg_refused |-> $past(taken && reg_req.addr > 8'h06))
      else $error("refusal without a fenced access");
   a_lock_readback: assert property (reg_rd_valid && $past(reg_req.addr) == 8'h06
      |-> reg_rdata == {7'h00, $past(pll_locked)}) else $error("lock flag read wrong");
   a_lock_wait: assert property ($rose(pll_locked) |-> on_reg >= LOCK_CYCLES)
      else $error("lock flag rose too early");
   a_lock_enabled: assert property (pll_locked |-> $past(pll_enable))
      else $error("lock flag with loop off");
   a_down_clears: assert property (s_held_down |=> !pll_enable && !pll_locked && !core_clock_gate)
      else $error("power-down left clocks running");
   a_reset_closed: assert property ($rose(rstn) |-> !core_clock_gate && !pll_locked)
      else $error("gate open out of reset");
endmodule // ccs_clock_setup_asserts

bind ccs_clock_setup ccs_clock_setup_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_ccs_clock_setup_asserts (
   .clock, .rstn, .clk_en, .power_down_pin_active_low, .reg_req, .reg_rdata,
   .reg_rd_valid, .reg_refused, .pll_enable, .pll_locked, .core_clock_gate
);

// ===== test/test_ccs_clock_setup.sv
// Self-checking bench for the clock setup block
`timescale 1ns/10ps
module test_ccs_clock_setup;
   import ccs_pkg::*;
   localparam int unsigned LOCK_CYCLES = 4;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic clk_en = 1'b1;
   logic power_down_pin_active_low = 1'b1;
   logic aux_tick = 1'b0;
   logic capture_serial_out_second_data = 1'b0;
   logic multipurpose_pin = 1'b0;
   ccs_reg_req_t reg_req = '0;
   logic [7:0] reg_rdata, got;
   logic reg_rd_valid, reg_refused, pll_enable, pll_locked, core_clock_gate, vld, refd;
   logic core_clock_halver, circuits_powered, auxiliary_clock_output, dac_mute;
   ccs_pll_cfg_t pll_cfg;
   int mismatches = 0;
   int tests_run = 0;

   ccs_clock_setup #(.LOCK_CYCLES(LOCK_CYCLES)) u_ccs_clock_setup (
      .clock, .rstn, .clk_en, .power_down_pin_active_low, .reg_req, .aux_tick,
      .capture_serial_out_second_data, .multipurpose_pin, .reg_rdata, .reg_rd_valid,
      .reg_refused, .pll_cfg, .pll_enable, .pll_locked, .core_clock_gate,
      .core_clock_halver, .circuits_powered, .auxiliary_clock_output, .dac_mute
   );

   // 5 ns half period gives 100 MHz
   always #5 clock = ~clock;

   task automatic chk(input logic c, input string m);
      tests_run++;
      if (c !== 1'b1) begin
         mismatches++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   // Request rises after a falling edge; the reply is sampled half a cycle after the taking edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req = '{wr: w, rd: ~w, addr: a, wdata: d};
      @(negedge clock);
      reg_req = '0;
      got = reg_rdata;
      vld = reg_rd_valid;
      refd = reg_refused;
   endtask

   // Polls the lock flag under a bound so a dead loop cannot hang the run
   task automatic wait_lock();
      int n = 0;
      got = 8'h00;
      while (got !== 8'h01 && n < 20) begin
         acc(1'b0, 8'h06, 8'h00);
         n++;
      end
      chk(got === 8'h01 && pll_locked === 1'b1 && pll_enable === 1'b1, "no lock");
      repeat (2) @(negedge clock);
   endtask

   // Counts pin toggles over 32 ticks; any divider phase gives 32 >> factor
   task automatic aux_run(input logic [7:0] ctl, output int tg);
      logic last;
      acc(1'b1, 8'h07, ctl);
      repeat (3) @(negedge clock);
      last = auxiliary_clock_output;
      tg = 0;
      repeat (32) begin
         aux_tick = 1'b1;
         @(negedge clock);
         aux_tick = 1'b0;
         repeat (2) begin
            @(negedge clock);
            tg += int'(auxiliary_clock_output !== last);
            last = auxiliary_clock_output;
         end
      end
   endtask

   task automatic t_reset();
      for (int a = 0; a < 7; a++) begin
         acc(1'b0, 8'(a), 8'h00);
         chk(vld === 1'b1 && got === 8'h00, "reset value");
      end
      acc(1'b1, 8'h06, 8'h01);
      acc(1'b0, 8'h06, 8'h00);
      chk(got === 8'h00, "lock flag written");
      acc(1'b1, 8'h00, 8'h02);
      @(negedge clock);
      chk(core_clock_halver === 1'b1 && circuits_powered === 1'b1, "halver");
      chk(core_clock_gate === 1'b0, "gate open");
      acc(1'b0, 8'h07, 8'h00);
      chk(refd === 1'b1 && vld === 1'b0, "read 07 taken");
      acc(1'b1, 8'h38, 8'h06);
      chk(refd === 1'b1, "write 38 taken");
      $display("reset test done");
   endtask

   task automatic t_program();
      logic [7:0] frac [5] = '{8'h00, 8'h7d, 8'h00, 8'h12, 8'h31};
      acc(1'b1, 8'h00, 8'h08);
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, 8'(i + 1), frac[i]);
      end
      @(negedge clock);
      chk(pll_cfg === ccs_pll_cfg_t'{2'h0, 4'h6, 16'h0012, 16'h007d, 1'b1}, "frac cfg");
      acc(1'b1, 8'h00, 8'h88);
      acc(1'b1, 8'h00, 8'h89);
      acc(1'b0, 8'h06, 8'h00);
      chk(got === 8'h00 && core_clock_gate === 1'b0, "gate early");
      chk(core_clock_halver === 1'b0, "halver kept");
      wait_lock();
      chk(core_clock_gate === 1'b1, "gate shut");
      acc(1'b0, 8'h38, 8'h00);
      chk(vld === 1'b1 && refd === 1'b0 && got === 8'h00, "fence held");
      $display("program test done");
   endtask

   task automatic t_integer();
      logic [7:0] mode [3] = '{8'h20, 8'h10, 8'h26};
      logic [3:0] mult [3] = '{4'h4, 4'h2, 4'h4};
      logic [1:0] div [3] = '{2'h0, 2'h0, 2'h3};
      acc(1'b1, 8'h00, 8'h09);
      repeat (2) @(negedge clock);
      chk(pll_locked === 1'b0 && core_clock_gate === 1'b0, "lock kept");
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, 8'h05, mode[i]);
         @(negedge clock);
         chk(pll_cfg === ccs_pll_cfg_t'{div[i], mult[i], 16'h0, 16'h0, 1'b0}, "int cfg");
      end
      acc(1'b1, 8'h05, 8'h20);
      acc(1'b1, 8'h00, 8'h89);
      wait_lock();
      $display("integer test done");
   endtask

   task automatic t_mute();
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 8'h38, {3'h0, i[1], 4'h6});
         multipurpose_pin = i[0];
         repeat (2) @(negedge clock);
         chk(dac_mute === (i[0] ^ i[1]), "mute level");
      end
      // Clock enable low: a write to clear the gate must not land
      clk_en = 1'b0;
      acc(1'b1, 8'h00, 8'h00);
      chk(core_clock_gate === 1'b1 && pll_locked === 1'b1 && vld === 1'b0, "freeze");
      clk_en = 1'b1;
      $display("mute test done");
   endtask

   task automatic t_aux();
      int tg;
      int want;
      for (int p = 0; p < 2; p++) begin
         for (int f = 0; f < 6; f++) begin
            aux_run({3'h0, 3'(f), 1'(p), 1'b1}, tg);
            want = (f > 4 || (p == 1 && f < 2)) ? 0 : 32 >> f;
            chk(tg == want, "aux toggles");
         end
      end
      acc(1'b1, 8'h07, 8'h00);
      for (int s = 0; s < 2; s++) begin
         capture_serial_out_second_data = 1'(s);
         repeat (3) @(negedge clock);
         chk(auxiliary_clock_output === 1'(s), "shared pin");
      end
      $display("aux test done");
   endtask

   task automatic t_down();
      // Mute through the inverted multipurpose pin before powering down
      multipurpose_pin = 1'b0;
      repeat (2) @(negedge clock);
      chk(dac_mute === 1'b1, "not muted");
      power_down_pin_active_low = 1'b0;
      repeat (3) @(negedge clock);
      chk(!circuits_powered && !pll_enable && !pll_locked && !core_clock_gate, "on");
      power_down_pin_active_low = 1'b1;
      repeat (2) @(negedge clock);
      acc(1'b0, 8'h00, 8'h00);
      chk(got === 8'h00 && vld === 1'b1, "regs kept");
      acc(1'b0, 8'h38, 8'h00);
      chk(refd === 1'b1, "fence open");
      $display("power-down test done");
   endtask

   task automatic end_of_test();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Tests need about 1350 cycles; the limit leaves a wide margin
   initial begin
      #200us;
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (16) @(negedge clock);
      rstn = 1'b1;
      t_reset();
      t_program();
      t_integer();
      t_mute();
      t_aux();
      t_down();
      end_of_test();
   end
endmodule // test_ccs_clock_setup
